// [src/sram_cycle_pkg.sv]
// Shared constants and types for the pipelined SRAM cycle control
package sram_cycle_pkg;
   localparam int ADDR_W = 18;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int BURST_W = 2;
   localparam int DESC_W = ADDR_W + 1;
   localparam int DESC_WR_BIT = ADDR_W;
   localparam int PEND_DEPTH = 8;
   localparam int MEM_WORDS = 1 << ADDR_W;
   localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic ORDER_LINEAR = 1'b1;
   localparam logic [DATA_W-1:0] DQ_RESET = 36'h0;
   localparam logic [LANES-1:0] LANES_OFF = 4'hF;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h0;

   typedef enum logic [1:0]
   {
      BURST_IDLE = 2'b00,
      BURST_READ = 2'b01,
      BURST_WRITE = 2'b10
   } burst_e;
endpackage

// [src/pend_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides
module pend_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr_ff, nxt_wr_ptr;
   logic [PTR_W-1:0] rd_ptr_ff, nxt_rd_ptr;
   logic [PTR_W:0] count_ff, nxt_count;
   logic push, pop;

   assign in_ready = (count_ff != (PTR_W+1)'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = store[rd_ptr_ff];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_count = count_ff;
      if (push)
      begin
         nxt_wr_ptr = (wr_ptr_ff == PTR_W'(DEPTH - 1)) ? '0
                      : PTR_W'(wr_ptr_ff + 1'b1);
      end
      if (pop)
      begin
         nxt_rd_ptr = (rd_ptr_ff == PTR_W'(DEPTH - 1)) ? '0
                      : PTR_W'(rd_ptr_ff + 1'b1);
      end
      if (push && !pop)
      begin
         nxt_count = (PTR_W+1)'(count_ff + 1'b1);
      end
      else if (pop && !push)
      begin
         nxt_count = (PTR_W+1)'(count_ff - 1'b1);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else
      begin
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         count_ff <= nxt_count;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
      begin
         store[wr_ptr_ff] <= in_data;
      end
   end
endmodule

// [src/pipelined_sram_cycle_control.sv]
// Cycle control, burst sequencing and storage of a pipelined burst SRAM
module pipelined_sram_cycle_control (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_hold,
   input wire logic chip_sel_n,
   input wire logic chip_select_aux_n,
   input wire logic chip_sel,
   input wire logic advance_load_n,
   input wire logic read_write,
   input wire logic burst_linear,
   input wire logic [sram_cycle_pkg::ADDR_W-1:0] addr,
   input wire logic [sram_cycle_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic [sram_cycle_pkg::DATA_W-1:0] dq_in,
   output logic [sram_cycle_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe
);
   import sram_cycle_pkg::*;

   logic [DATA_W-1:0] mem [MEM_WORDS];

   logic en, selected, load;
   burst_e burst_state_ff, nxt_burst_state;
   logic [BURST_W-1:0] burst_cnt_ff, nxt_burst_cnt;
   logic [ADDR_W-1:0] base_addr_ff, nxt_base_addr;
   logic burst_order_ff, nxt_burst_order;
   logic issue, issue_wr;
   logic [ADDR_W-1:0] issue_addr;
   logic fifo_in_ready, fifo_out_valid;
   logic [DESC_W-1:0] fifo_out_data;
   logic s2_valid_ff, nxt_s2_valid;
   logic s2_wr_ff, nxt_s2_wr;
   logic [ADDR_W-1:0] s2_addr_ff, nxt_s2_addr;
   logic [LANES-1:0] s2_bw_n_ff, nxt_s2_bw_n;
   logic [DATA_W-1:0] dq_out_ff, nxt_dq_out;
   logic dq_oe_ff, nxt_dq_oe;

   // Low address bits of a burst beat, linear or interleaved
   function automatic logic [BURST_W-1:0] burst_low(
      input logic [BURST_W-1:0] base,
      input logic [BURST_W-1:0] cnt,
      input logic linear
   );
      logic [BURST_W-1:0] res;
      res = (linear == ORDER_LINEAR) ? BURST_W'(base + cnt) : (base ^ cnt);
      return res;
   endfunction

   assign en = !clk_hold;
   assign selected = !chip_sel_n && !chip_select_aux_n && chip_sel;
   assign load = !advance_load_n;

   // Command stage: load, burst advance, deselect
   always_comb
   begin
      nxt_burst_state = burst_state_ff;
      nxt_burst_cnt = burst_cnt_ff;
      nxt_base_addr = base_addr_ff;
      nxt_burst_order = burst_order_ff;
      issue = 1'b0;
      issue_wr = 1'b0;
      issue_addr = base_addr_ff;
      if (en)
      begin
         if (!selected)
         begin
            nxt_burst_state = BURST_IDLE;
         end
         else if (load)
         begin
            issue = 1'b1;
            issue_wr = !read_write;
            issue_addr = addr;
            nxt_base_addr = addr;
            nxt_burst_cnt = BURST_FIRST;
            nxt_burst_order = burst_linear;
            nxt_burst_state = read_write ? BURST_READ : BURST_WRITE;
         end
         else
         begin
            case (burst_state_ff)
               BURST_READ, BURST_WRITE:
               begin
                  issue = 1'b1;
                  issue_wr = (burst_state_ff == BURST_WRITE);
                  nxt_burst_cnt = BURST_W'(burst_cnt_ff + BURST_STEP);
                  issue_addr = {base_addr_ff[ADDR_W-1:BURST_W],
                                burst_low(base_addr_ff[BURST_W-1:0],
                                          nxt_burst_cnt,
                                          burst_order_ff)};
               end
               default:
               begin
                  issue = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         burst_state_ff <= BURST_IDLE;
         burst_cnt_ff <= BURST_FIRST;
         base_addr_ff <= ADDR_RESET;
         burst_order_ff <= ORDER_LINEAR;
      end
      else
      begin
         burst_state_ff <= nxt_burst_state;
         burst_cnt_ff <= nxt_burst_cnt;
         base_addr_ff <= nxt_base_addr;
         burst_order_ff <= nxt_burst_order;
      end
   end

   // Accepted beats wait here for their byte-enable cycle
   pend_fifo #(
      .WIDTH(DESC_W),
      .DEPTH(PEND_DEPTH)
   ) u_pend (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(issue),
      .in_ready(fifo_in_ready),
      .in_data({issue_wr, issue_addr}),
      .out_valid(fifo_out_valid),
      .out_ready(en),
      .out_data(fifo_out_data)
   );

   // Byte-enable stage, one cycle after the command
   always_comb
   begin
      nxt_s2_valid = s2_valid_ff;
      nxt_s2_wr = s2_wr_ff;
      nxt_s2_addr = s2_addr_ff;
      nxt_s2_bw_n = s2_bw_n_ff;
      if (en)
      begin
         nxt_s2_valid = fifo_out_valid;
         nxt_s2_wr = fifo_out_data[DESC_WR_BIT];
         nxt_s2_addr = fifo_out_data[ADDR_W-1:0];
         nxt_s2_bw_n = fifo_out_valid ? byte_lane_write_n : LANES_OFF;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s2_valid_ff <= 1'b0;
         s2_wr_ff <= 1'b0;
         s2_addr_ff <= ADDR_RESET;
         s2_bw_n_ff <= LANES_OFF;
      end
      else
      begin
         s2_valid_ff <= nxt_s2_valid;
         s2_wr_ff <= nxt_s2_wr;
         s2_addr_ff <= nxt_s2_addr;
         s2_bw_n_ff <= nxt_s2_bw_n;
      end
   end

   // Data stage, two cycles after the command
   always_comb
   begin
      nxt_dq_out = dq_out_ff;
      nxt_dq_oe = dq_oe_ff;
      if (en)
      begin
         nxt_dq_oe = s2_valid_ff && !s2_wr_ff;
         if (s2_valid_ff && !s2_wr_ff)
         begin
            nxt_dq_out = mem[s2_addr_ff];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dq_out_ff <= DQ_RESET;
         dq_oe_ff <= 1'b0;
      end
      else
      begin
         dq_out_ff <= nxt_dq_out;
         dq_oe_ff <= nxt_dq_oe;
      end
   end

   // Write data is taken the cycle after its byte enables
   always_ff @(posedge clk_sys)
   begin
      if (en && s2_valid_ff && s2_wr_ff)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (!s2_bw_n_ff[i])
            begin
               mem[s2_addr_ff][i*LANE_W +: LANE_W] <=
                  dq_in[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   assign dq_out = dq_out_ff;
   assign dq_oe = dq_oe_ff;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   chk_write_start: assert property (
      (en && selected && load && !read_write && fifo_in_ready)
      |=> (fifo_out_valid && fifo_out_data[DESC_WR_BIT]))
      else $error("write load did not queue a write beat");
   chk_hold_ignore: assert property (
      clk_hold |=> ($stable(fifo_out_valid) && $stable(base_addr_ff)
                    && $stable(burst_order_ff)))
      else $error("held edge was not ignored");
   chk_hold_freeze: assert property (
      clk_hold |=> ($stable(dq_out_ff) && $stable(dq_oe_ff)
                    && $stable(s2_valid_ff) && $stable(s2_bw_n_ff)
                    && $stable(burst_cnt_ff) && $stable(burst_state_ff)))
      else $error("state changed on a held edge");
   chk_deselect_block: assert property (
      (en && !selected) |-> ##1 (burst_state_ff == BURST_IDLE))
      else $error("deselect left a burst running");
   chk_bus_float: assert property (
      (en && !selected) ##1 en ##1 en |=> !dq_oe_ff)
      else $error("bus still driven after deselect");
   chk_pending_read: assert property (
      (en && s2_valid_ff && !s2_wr_ff) |=> (dq_oe_ff
         && dq_out_ff === $past(mem[s2_addr_ff])))
      else $error("accepted read did not drive the bus");
   chk_burst_reload: assert property (
      (en && selected && load) |=> (burst_cnt_ff == BURST_FIRST
         && base_addr_ff == $past(addr)))
      else $error("load did not restart the burst");
   chk_burst_dir: assert property (
      (en && selected && !load && burst_state_ff == BURST_WRITE)
      |=> burst_state_ff == BURST_WRITE)
      else $error("burst direction changed while bursting");
   chk_burst_step: assert property (
      (en && selected && !load && burst_state_ff != BURST_IDLE)
      |=> burst_cnt_ff == BURST_W'($past(burst_cnt_ff) + BURST_STEP))
      else $error("burst counter did not advance by one");
   chk_bw_sample: assert property (
      (en && fifo_out_valid)
      |=> s2_bw_n_ff == $past(byte_lane_write_n))
      else $error("byte enables not taken one cycle after command");

   cov_write_load: cover property (
      en && selected && load && !read_write);
   cov_read_burst: cover property (
      (en && selected && load && read_write) ##1 (en && !load) [*3]);
   cov_hold_read: cover property (
      (s2_valid_ff && !s2_wr_ff) ##0 clk_hold ##1 !clk_hold);
   cov_deselect: cover property (
      dq_oe_ff ##1 (en && !selected) ##2 !dq_oe_ff);
endmodule

// [testbench/host_lane_model.sv]
// Host side model: byte enables and write data trail each command
module host_lane_model (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic clk_hold,
   input wire logic [sram_cycle_pkg::LANES-1:0] be_req_n,
   input wire logic [sram_cycle_pkg::DATA_W-1:0] data_req,
   output logic [sram_cycle_pkg::LANES-1:0] byte_lane_write_n,
   output logic [sram_cycle_pkg::DATA_W-1:0] dq_in
);
   timeunit 1ns;
   timeprecision 1ns;
   import sram_cycle_pkg::*;
   logic [DATA_W-1:0] data_ff;
   // Held edges stall the host pipeline as well
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         byte_lane_write_n <= LANES_OFF;
         data_ff <= DQ_RESET;
         dq_in <= DQ_RESET;
      end
      else if (!clk_hold)
      begin
         byte_lane_write_n <= be_req_n;
         data_ff <= data_req;
         dq_in <= data_ff;
      end
   end
endmodule

// [testbench/tb_pipelined_sram_cycle_control.sv]
// Self-checking bench with a cycle model of the SRAM control
module tb_pipelined_sram_cycle_control;
   timeunit 1ns;
   timeprecision 1ns;
   import sram_cycle_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic clk_hold = 1'b0, chip_sel_n = 1'b1, chip_select_aux_n = 1'b1;
   logic chip_sel = 1'b0, advance_load_n = 1'b1, read_write = 1'b1;
   logic burst_linear = ORDER_LINEAR, dq_oe;
   logic [ADDR_W-1:0] addr = ADDR_RESET;
   logic [LANES-1:0] be_req_n = LANES_OFF, byte_lane_write_n;
   logic [DATA_W-1:0] data_req = DQ_RESET, dq_in, dq_out;
   int mismatches = 0, n_tests = 0, cycles = 0;
   integer seed = 32'hFBAE882A;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic s1_v, s1_wr, s2_v, s2_wr, b_on, b_wr, b_lin, exp_oe;
   logic [ADDR_W-1:0] s1_a, s2_a, b_base;
   logic [1:0] b_cnt;
   logic [LANES-1:0] s2_be;
   logic [DATA_W-1:0] exp_q;
   logic [2:0] seed_sel [3] = '{3'h6, 3'h5, 3'h3};

   always #50 clk_sys = ~clk_sys;

   pipelined_sram_cycle_control u_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .clk_hold(clk_hold),
      .chip_sel_n(chip_sel_n), .chip_select_aux_n(chip_select_aux_n),
      .chip_sel(chip_sel), .advance_load_n(advance_load_n),
      .read_write(read_write), .burst_linear(burst_linear), .addr(addr),
      .byte_lane_write_n(byte_lane_write_n), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe));

   host_lane_model u_host (
      .clk_sys(clk_sys), .arst_n(arst_n), .clk_hold(clk_hold),
      .be_req_n(be_req_n), .data_req(data_req),
      .byte_lane_write_n(byte_lane_write_n), .dq_in(dq_in));

   function automatic logic [ADDR_W-1:0] beat_addr(
      input logic [ADDR_W-1:0] base, input logic [1:0] cnt, input logic lin);
      return {base[ADDR_W-1:2], lin ? base[1:0] + cnt : base[1:0] ^ cnt};
   endfunction

   task automatic check(input logic [DATA_W-1:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_oe(input logic got, exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic drive(input logic h, input logic [2:0] s,
      input logic ld_n, rw, input logic [ADDR_W-1:0] a, input logic lin);
      @(posedge clk_sys);
      clk_hold <= h;
      chip_sel_n <= !s[0];
      chip_select_aux_n <= !s[1];
      chip_sel <= s[2];
      advance_load_n <= ld_n;
      read_write <= rw;
      addr <= a;
      burst_linear <= lin;
      be_req_n <= LANES'($random(seed));
      data_req <= DATA_W'({$random(seed), $random(seed)});
   endtask

   // Reference pipeline: command, byte enable stage, data stage
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_v = 1'b0;
         s2_v = 1'b0;
         b_on = 1'b0;
         exp_oe = 1'b0;
      end
      else if (!clk_hold)
      begin
         exp_oe = 1'b0;
         if (s2_v && s2_wr)
         begin
            if (!mem.exists(s2_a))
               mem[s2_a] = 'x;
            for (int i = 0; i < LANES; i++)
               if (!s2_be[i])
                  mem[s2_a][i*LANE_W +: LANE_W] = dq_in[i*LANE_W +: LANE_W];
         end
         else if (s2_v)
         begin
            exp_oe = 1'b1;
            exp_q = mem.exists(s2_a) ? mem[s2_a] : 'x;
         end
         s2_v = s1_v;
         s2_wr = s1_wr;
         s2_a = s1_a;
         s2_be = byte_lane_write_n;
         s1_v = 1'b0;
         if (chip_sel_n || chip_select_aux_n || !chip_sel)
            b_on = 1'b0;
         else if (!advance_load_n)
         begin
            b_on = 1'b1;
            b_wr = !read_write;
            b_lin = burst_linear;
            b_base = addr;
            b_cnt = 2'h0;
            s1_v = 1'b1;
         end
         else if (b_on)
         begin
            b_cnt++;
            s1_v = 1'b1;
         end
         s1_wr = b_wr;
         s1_a = beat_addr(b_base, b_cnt, b_lin);
      end
   end

   always @(negedge clk_sys)
   begin
      if (arst_n)
      begin
         check_oe(dq_oe, exp_oe);
         if (exp_oe)
            check(dq_out, exp_q);
      end
      cycles++;
      if (cycles > 8000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Write burst wrapping past four beats, held load edge inside
      drive(0, 7, 0, 0, 18'h00013, 1);
      drive(1, 7, 0, 1, 18'h00020, 0);
      repeat (5) drive(0, 7, 1, 1, 18'h00000, 0);
      drive(0, 7, 0, 1, 18'h00012, 0);
      repeat (5) drive(0, 7, 1, 0, 18'h00000, 1);
      // Deselect in mid read burst through each select in turn
      foreach (seed_sel[k])
      begin
         drive(0, 7, 0, 1, 18'h00011, 1);
         drive(0, 7, 1, 0, 18'h00000, 1);
         drive(0, seed_sel[k], k == 1, 1, 18'h00022, 1);
         drive(0, 7, 1, 1, 18'h00000, 1);
      end
      for (int i = 0; i < 6; i++)
         drive(0, 7, 0, 1'(i), 18'h00030, 1);
      repeat (3000)
         drive(($random(seed) & 7) == 0,
            ($random(seed) & 7) == 0 ? 3'($random(seed)) : 3'h7,
            1'($random(seed)), 1'($random(seed)),
            ADDR_W'($random(seed) & 15), 1'($random(seed)));
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      drive(0, 7, 0, 1, 18'h00013, 1);
      repeat (4) drive(0, 0, 1, 1, 18'h00000, 1);
      wrap_up();
   end
endmodule
